/* File: icp_pkg.sv */
// Shared constants and types for the isolated control port logic.
package icp_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam int unsigned ON_RESP_US = 100;
	localparam int unsigned OFF_RESP_US = 1000;
	localparam int unsigned SYNC_LAT_CYC = 3;
	localparam int unsigned MS_W = 9;
	localparam logic [8:0] FILTER_MS_MIN = 9'h032;
	localparam logic [8:0] FILTER_MS_MAX = 9'h1F4;
	localparam logic [8:0] FILTER_MS_DEF = 9'h032;
	localparam logic FILTER_EN_DEF = 1'b0;
	localparam logic [8:0] PULSE_MS_MIN = 9'h001;
	localparam logic [8:0] PULSE_MS_MAX = 9'h064;
	localparam logic [8:0] PULSE_MS_DEF = 9'h005;
	localparam logic [8:0] INT_PULSE_MS = 9'h005;
	localparam logic DONE_PULSE_DEF = 1'b0;
	localparam logic MEASURE_START_EXT_DEF = 1'b0;
	localparam logic MEASURE_START_OFF_EDGE_DEF = 1'b0;
	localparam logic DIGIT_MODE_DEF = 1'b0;
	localparam logic AUTO_CAL_DEF = 1'b1;
	localparam logic DATA_OUT_DEF = 1'b0;
	localparam int unsigned IN_W = 14;
	localparam int unsigned IN_START = 0;
	localparam int unsigned IN_CAL = 1;
	localparam int unsigned IN_LOCK = 2;
	localparam int unsigned IN_ZERO = 3;
	localparam int unsigned IN_PRINT = 4;
	localparam int unsigned IN_SCANSEL = 5;
	localparam int unsigned IN_HALT = 6;
	localparam int unsigned IN_PRESET = 7;
	localparam int unsigned IN_HALF = 13;
	localparam int unsigned OUT_W = 40;
	localparam int unsigned DIGIT_W = 28;
	localparam int unsigned DIGIT_LINES_W = 12;
	typedef enum logic [1:0] {
		ICP_SCAN_OFF = 2'h0,
		ICP_SCAN_AUTO = 2'h1,
		ICP_SCAN_STEP = 2'h2
	} icp_scan_t;
	typedef enum logic [1:0] {
		ICP_DONE_IDLE = 2'b00,
		ICP_DONE_HELD = 2'b01,
		ICP_DONE_PULSE = 2'b11
	} icp_done_t;
endpackage

/* File: icp_tmr_if.sv */
// Control and status bundle between the port logic and one millisecond timer.
`timescale 1ns/1ps
interface icp_tmr_if;
	logic start;
	logic hold;
	logic [8:0] limit_ms;
	logic expired;
	logic busy;
	modport ctl (output start, output hold, output limit_ms, input expired, input busy);
	modport tmr (input start, input hold, input limit_ms, output expired, output busy);
endinterface

/* File: icp_sync.sv */
// Three-stage input synchroniser; a change counts once stages two and three agree.
`timescale 1ns/1ps
module icp_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	wire logic [W-1:0] agree = ~(s2_r ^ s3_r);
	// Stage one feeds only stage two, so no decision sees a metastable value.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			dout <= '0;
		end
		else
		begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			dout <= (agree & s3_r) | (~agree & dout);
		end
	end
endmodule

/* File: icp_ms_timer.sv */
// Millisecond timer that restarts on start and aborts when hold drops.
`timescale 1ns/1ps
module icp_ms_timer #(
	parameter int unsigned CYC_PER_MS = icp_pkg::CYC_PER_MS
) (
	input wire logic clk,
	input wire logic sys_rst,
	icp_tmr_if.tmr t
);
	logic [16:0] cyc_r;
	logic [8:0] ms_r;
	logic run_r;
	wire logic ms_tick = (cyc_r == 17'(CYC_PER_MS - 1));
	wire logic last_ms = (ms_r == t.limit_ms - 9'h001);
	// Expiry is flagged in the last counted cycle, so a pulse lasts exactly limit_ms.
	assign t.expired = run_r & t.hold & ms_tick & last_ms & ~t.start;
	// The prescaler restarts with the count, so a width is never short by a tick phase.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cyc_r <= '0;
			ms_r <= '0;
			run_r <= 1'b0;
		end
		else
		begin
			if (t.start)
			begin
				cyc_r <= '0;
				ms_r <= '0;
				run_r <= 1'b1;
			end
			else if (run_r && !t.hold)
				run_r <= 1'b0;
			else if (run_r)
			begin
				cyc_r <= ms_tick ? 17'h0_0000 : cyc_r + 17'h0_0001;
				if (ms_tick)
				begin
					ms_r <= ms_r + 9'h001;
					if (last_ms)
						run_r <= 1'b0;
				end
			end
		end
	end
	assign t.busy = run_r;
endmodule

/* File: icp_port.sv */
// Isolated control port: trigger, filters, output mode selection and done timing.
// Operation
// - Accept start, calibration, lockout, zero, print, scanner, halt, presets.
// - Half-select honoured only in digit mode.
// - Verdict or digit output mode; verdict default.
// - Verdict mode drives verdict, class, code outputs.
// - Digit mode: done, fault, pass, limits, high digits.
// - Half-select off puts digits four to seven out.
// - Inputs recognised within 0.1 ms on, 1.0 ms off.
// - Trigger internal by default; scanning forces external.
// - Filter needs trigger or print held whole time.
// - Trigger acts on on-going or off-going edge.
// - Latched done holds until start or zero request.
// - Pulse done drops after programmed width elapses.
// - Internal trigger: 5 ms done or none.
// - Test mode shows inputs, forces outputs.
// - Internal trigger start sends value when enabled.
// - Auto scan measures all channels; step one.
`timescale 1ns/1ps
module icp_port #(
	parameter int unsigned CYC_PER_MS = icp_pkg::CYC_PER_MS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic measure_start_pin,
	input wire logic self_cal_pin,
	input wire logic panel_lock_pin,
	input wire logic zero_offset_request_pin,
	input wire logic print_pin,
	input wire logic scanner_terminal_select_pin,
	input wire logic sweep_halt_pin,
	input wire logic [5:0] preset_select_lines_pin,
	input wire logic digit_half_select_pin,
	input wire logic cfg_wr,
	input wire logic cfg_digit_mode,
	input wire logic cfg_measure_start_external,
	input wire logic [1:0] cfg_scan_mode,
	input wire logic cfg_filter_en,
	input wire logic [8:0] cfg_filter_ms,
	input wire logic cfg_measure_start_off_edge,
	input wire logic cfg_done_pulse,
	input wire logic [8:0] cfg_pulse_ms,
	input wire logic cfg_auto_cal,
	input wire logic cfg_data_out_en,
	input wire logic test_mode,
	input wire logic [39:0] test_out,
	input wire logic res_valid,
	input wire logic res_fault,
	input wire logic res_ready,
	input wire logic res_upper,
	input wire logic res_pass,
	input wire logic res_lower,
	input wire logic [2:0] res_temp,
	input wire logic [9:0] res_class,
	input wire logic res_overflow,
	input wire logic [2:0] res_code,
	input wire logic [27:0] res_digits,
	input wire logic [3:0] res_range,
	output logic [13:0] test_in_state,
	output logic measure_start_external_eff,
	output logic meas_req,
	output logic meas_all_channels,
	output logic zero_req,
	output logic print_req,
	output logic host_send_req,
	output logic self_cal_req,
	output logic panel_lock,
	output logic sweep_halt,
	output logic [5:0] preset_select,
	output logic measure_done,
	output logic fault,
	output logic ready_next,
	output logic upper_verdict,
	output logic pass_verdict,
	output logic lower_verdict,
	output logic [2:0] temp_verdict,
	output logic [9:0] class_lines,
	output logic overflow_class,
	output logic [2:0] verdict_code_lines,
	output logic outside_limits,
	output logic [11:0] digit_lines,
	output logic [3:0] range_code_lines
);
	logic [13:0] pin_vec;
	logic [13:0] in_s;
	logic [13:0] in_d_r;
	logic digit_mode_r;
	logic measure_start_ext_r;
	logic [1:0] scan_r;
	logic filt_en_r;
	logic [8:0] filt_ms_r;
	logic off_edge_r;
	logic done_pulse_r;
	logic [8:0] pulse_ms_r;
	logic auto_cal_r;
	logic data_out_r;
	logic measure_start_qual_r;
	logic res_fault_r;
	logic res_ready_r;
	logic res_upper_r;
	logic res_pass_r;
	logic res_lower_r;
	logic [2:0] res_temp_r;
	logic [9:0] res_class_r;
	logic res_ob_r;
	logic [2:0] res_code_r;
	logic [27:0] res_digits_r;
	logic [3:0] res_range_r;
	logic [39:0] out_r;
	logic [39:0] out_nxt;
	icp_pkg::icp_done_t done_st_r;
	icp_pkg::icp_done_t done_st_nxt;
	icp_tmr_if measure_start_t ();
	icp_tmr_if print_t ();
	icp_tmr_if done_t ();

	// Inputs arrive as on-levels; the synchroniser adds four cycles, 40 ns, far inside both response limits.
	assign pin_vec = {digit_half_select_pin, preset_select_lines_pin, sweep_halt_pin,
		scanner_terminal_select_pin, print_pin, zero_offset_request_pin,
		panel_lock_pin, self_cal_pin, measure_start_pin};
	icp_sync #(.W(icp_pkg::IN_W)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.din(pin_vec),
		.dout(in_s)
	);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			in_d_r <= '0;
		else
			in_d_r <= in_s;
	end

	wire logic start_on = in_s[icp_pkg::IN_START];
	wire logic start_rise = start_on & ~in_d_r[icp_pkg::IN_START];
	wire logic start_fall = ~start_on & in_d_r[icp_pkg::IN_START];
	wire logic print_on = in_s[icp_pkg::IN_PRINT];
	wire logic print_rise = print_on & ~in_d_r[icp_pkg::IN_PRINT];
	wire logic zero_rise = in_s[icp_pkg::IN_ZERO] & ~in_d_r[icp_pkg::IN_ZERO];
	wire logic scan_sel = in_s[icp_pkg::IN_SCANSEL];
	wire logic half_on = in_s[icp_pkg::IN_HALF];

	// Configuration is captured on a write strobe; out-of-range times are clamped.
	wire logic [8:0] filt_ms_cl = (cfg_filter_ms < icp_pkg::FILTER_MS_MIN) ? icp_pkg::FILTER_MS_MIN :
		(cfg_filter_ms > icp_pkg::FILTER_MS_MAX) ? icp_pkg::FILTER_MS_MAX : cfg_filter_ms;
	wire logic [8:0] pulse_ms_cl = (cfg_pulse_ms < icp_pkg::PULSE_MS_MIN) ? icp_pkg::PULSE_MS_MIN :
		(cfg_pulse_ms > icp_pkg::PULSE_MS_MAX) ? icp_pkg::PULSE_MS_MAX : cfg_pulse_ms;
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			digit_mode_r <= icp_pkg::DIGIT_MODE_DEF;
			measure_start_ext_r <= icp_pkg::MEASURE_START_EXT_DEF;
			scan_r <= icp_pkg::ICP_SCAN_OFF;
			filt_en_r <= icp_pkg::FILTER_EN_DEF;
			filt_ms_r <= icp_pkg::FILTER_MS_DEF;
			off_edge_r <= icp_pkg::MEASURE_START_OFF_EDGE_DEF;
			done_pulse_r <= icp_pkg::DONE_PULSE_DEF;
			pulse_ms_r <= icp_pkg::PULSE_MS_DEF;
			auto_cal_r <= icp_pkg::AUTO_CAL_DEF;
			data_out_r <= icp_pkg::DATA_OUT_DEF;
		end
		else if (cfg_wr)
		begin
			digit_mode_r <= cfg_digit_mode;
			measure_start_ext_r <= cfg_measure_start_external;
			scan_r <= cfg_scan_mode;
			filt_en_r <= cfg_filter_en;
			filt_ms_r <= filt_ms_cl;
			off_edge_r <= cfg_measure_start_off_edge;
			done_pulse_r <= cfg_done_pulse;
			pulse_ms_r <= pulse_ms_cl;
			auto_cal_r <= cfg_auto_cal;
			data_out_r <= cfg_data_out_en;
		end
	end

	wire logic scanning = scan_sel &&
		(scan_r == icp_pkg::ICP_SCAN_AUTO || scan_r == icp_pkg::ICP_SCAN_STEP);
	wire logic ext_eff = measure_start_ext_r | scanning;

	// Filter timers run only while the input stays on and restart on each on-going edge.
	assign measure_start_t.start = start_rise;
	assign measure_start_t.hold = start_on;
	assign measure_start_t.limit_ms = filt_ms_r;
	assign print_t.start = print_rise;
	assign print_t.hold = print_on;
	assign print_t.limit_ms = filt_ms_r;
	icp_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_measure_start_tmr (
		.clk(clk),
		.sys_rst(sys_rst),
		.t(measure_start_t)
	);
	icp_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_print_tmr (
		.clk(clk),
		.sys_rst(sys_rst),
		.t(print_t)
	);

	// Off-edge triggering with the filter on needs the full hold time before release.
	always_ff @(posedge clk)
	begin
		if (sys_rst || start_rise)
			measure_start_qual_r <= 1'b0;
		else if (measure_start_t.expired)
			measure_start_qual_r <= 1'b1;
		else if (start_fall)
			measure_start_qual_r <= 1'b0;
	end

	wire logic measure_start_on_evt = filt_en_r ? measure_start_t.expired : start_rise;
	wire logic measure_start_off_evt = start_fall & (~filt_en_r | measure_start_qual_r);
	wire logic measure_start_evt = off_edge_r ? measure_start_off_evt : measure_start_on_evt;
	wire logic print_evt = filt_en_r ? print_t.expired : print_rise;

	assign meas_req = measure_start_evt & ext_eff;
	assign meas_all_channels = scanning && scan_r == icp_pkg::ICP_SCAN_AUTO;
	assign host_send_req = measure_start_evt & ~ext_eff & data_out_r;
	assign print_req = print_evt;
	assign zero_req = zero_rise;
	assign measure_start_external_eff = ext_eff;
	assign self_cal_req = in_s[icp_pkg::IN_CAL];
	assign panel_lock = in_s[icp_pkg::IN_LOCK];
	assign sweep_halt = in_s[icp_pkg::IN_HALT];
	assign preset_select = in_s[icp_pkg::IN_PRESET +: 6];
	assign test_in_state = in_s;

	// Done timing: latched, programmed pulse, or fixed pulse under the internal source.
	wire logic int_done = ~ext_eff & auto_cal_r;
	wire logic done_clear = measure_start_evt | zero_rise;
	wire logic use_pulse = ext_eff ? done_pulse_r : 1'b1;
	assign done_t.start = res_valid & (ext_eff ? done_pulse_r : int_done);
	assign done_t.hold = 1'b1;
	assign done_t.limit_ms = ext_eff ? pulse_ms_r : icp_pkg::INT_PULSE_MS;
	icp_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_done_tmr (
		.clk(clk),
		.sys_rst(sys_rst),
		.t(done_t)
	);

	always_comb
	begin
		done_st_nxt = done_st_r;
		unique case (done_st_r)
			icp_pkg::ICP_DONE_IDLE:
			begin
				if (res_valid && use_pulse && (ext_eff || int_done))
					done_st_nxt = icp_pkg::ICP_DONE_PULSE;
				else if (res_valid && !use_pulse)
					done_st_nxt = icp_pkg::ICP_DONE_HELD;
			end
			icp_pkg::ICP_DONE_HELD:
			begin
				// A completion in the same cycle as a clear keeps the output on.
				if (done_clear && !res_valid)
					done_st_nxt = icp_pkg::ICP_DONE_IDLE;
			end
			icp_pkg::ICP_DONE_PULSE:
			begin
				if (done_t.expired && !res_valid)
					done_st_nxt = icp_pkg::ICP_DONE_IDLE;
			end
			default:
				done_st_nxt = icp_pkg::ICP_DONE_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			done_st_r <= icp_pkg::ICP_DONE_IDLE;
		else
			done_st_r <= done_st_nxt;
	end

	// Results are latched on completion so the pins hold steady between measurements.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			{res_fault_r, res_ready_r, res_upper_r, res_pass_r, res_lower_r} <= 5'h00;
			res_temp_r <= '0;
			res_class_r <= '0;
			res_ob_r <= 1'b0;
			res_code_r <= '0;
			res_digits_r <= '0;
			res_range_r <= '0;
		end
		else if (res_valid)
		begin
			{res_fault_r, res_ready_r, res_upper_r, res_pass_r, res_lower_r} <=
				{res_fault, res_ready, res_upper, res_pass, res_lower};
			res_temp_r <= res_temp;
			res_class_r <= res_class;
			res_ob_r <= res_overflow;
			res_code_r <= res_code;
			res_digits_r <= res_digits;
			res_range_r <= res_range;
		end
	end

	wire logic done_lvl = (done_st_nxt != icp_pkg::ICP_DONE_IDLE);
	wire logic half_eff = digit_mode_r & half_on;
	// A completing result goes straight to the pins, so they change together with done.
	wire logic [53:0] res_held = {res_range_r, res_digits_r, res_code_r, res_ob_r, res_class_r,
		res_temp_r, res_lower_r, res_pass_r, res_upper_r, res_ready_r, res_fault_r};
	wire logic [53:0] res_now = res_valid ? {res_range, res_digits, res_code, res_overflow,
		res_class, res_temp, res_lower, res_pass, res_upper, res_ready, res_fault} : res_held;
	wire logic outside_now = res_now[2] | res_now[4];
	wire logic [11:0] digits_hi = res_now[33:22];
	wire logic [15:0] digits_lo = res_now[49:34];
	wire logic [39:0] verdict_vec = {17'h0_0000, res_now[21:0], done_lvl};
	wire logic [39:0] digit_hi_vec = {res_now[53:50], digits_hi, outside_now,
		18'h0_0000, res_now[3], 2'h0, res_now[0], done_lvl};
	// With half-select off the range lines carry the top nibble of the low digits.
	wire logic [39:0] digit_lo_vec = {digits_lo, outside_now,
		18'h0_0000, res_now[3], 2'h0, res_now[0], done_lvl};

	assign out_nxt = test_mode ? test_out :
		!digit_mode_r ? verdict_vec :
		half_eff ? digit_hi_vec : digit_lo_vec;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			out_r <= '0;
		else
			out_r <= out_nxt;
	end

	assign measure_done = out_r[0];
	assign fault = out_r[1];
	assign ready_next = out_r[2];
	assign upper_verdict = out_r[3];
	assign pass_verdict = out_r[4];
	assign lower_verdict = out_r[5];
	assign temp_verdict = out_r[8:6];
	assign class_lines = out_r[18:9];
	assign overflow_class = out_r[19];
	assign verdict_code_lines = out_r[22:20];
	assign outside_limits = out_r[23];
	assign digit_lines = out_r[35:24];
	assign range_code_lines = out_r[39:36];
endmodule

/* File: icp_port_props.sv */
// Concurrent checks on the ports of the isolated control port.
`timescale 1ns/1ps
module icp_port_props #(
	parameter int unsigned CYC_PER_MS = icp_pkg::CYC_PER_MS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sweep_halt_pin,
	input wire logic cfg_wr,
	input wire logic cfg_digit_mode,
	input wire logic [1:0] cfg_scan_mode,
	input wire logic cfg_filter_en,
	input wire logic [8:0] cfg_filter_ms,
	input wire logic cfg_done_pulse,
	input wire logic [8:0] cfg_pulse_ms,
	input wire logic cfg_auto_cal,
	input wire logic cfg_data_out_en,
	input wire logic test_mode,
	input wire logic [39:0] test_out,
	input wire logic res_valid,
	input wire logic res_upper,
	input wire logic res_lower,
	input wire logic [9:0] res_class,
	input wire logic [27:0] res_digits,
	input wire logic [3:0] res_range,
	input wire logic [13:0] test_in_state,
	input wire logic measure_start_external_eff,
	input wire logic meas_req,
	input wire logic zero_req,
	input wire logic print_req,
	input wire logic host_send_req,
	input wire logic sweep_halt,
	input wire logic measure_done,
	input wire logic fault,
	input wire logic ready_next,
	input wire logic upper_verdict,
	input wire logic pass_verdict,
	input wire logic lower_verdict,
	input wire logic [2:0] temp_verdict,
	input wire logic [9:0] class_lines,
	input wire logic overflow_class,
	input wire logic [2:0] verdict_code_lines,
	input wire logic outside_limits,
	input wire logic [11:0] digit_lines,
	input wire logic [3:0] range_code_lines
);
	logic dm_r, pul_r, ac_r, de_r, fe_r;
	logic [1:0] sc_r;
	logic [8:0] fms_r, pms_r;
	logic [31:0] hi_r, ph_r;
	wire logic [39:0] outs = {range_code_lines, digit_lines, outside_limits, verdict_code_lines,
		overflow_class, class_lines, temp_verdict, lower_verdict, pass_verdict, upper_verdict,
		ready_next, fault, measure_done};
	// Shadow of the captured settings, so the checks know the active modes.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			{dm_r, pul_r, ac_r, de_r, fe_r} <= 5'h04;
			{sc_r, fms_r, pms_r} <= {2'h0, icp_pkg::FILTER_MS_DEF, icp_pkg::PULSE_MS_DEF};
		end
		else if (cfg_wr)
		begin
			{dm_r, pul_r, ac_r, de_r, fe_r} <= {cfg_digit_mode, cfg_done_pulse, cfg_auto_cal,
				cfg_data_out_en, cfg_filter_en};
			{sc_r, fms_r, pms_r} <= {cfg_scan_mode, cfg_filter_ms, cfg_pulse_ms};
		end
	end
	// A new result restarts the high-time count, as the done timer restarts too.
	always_ff @(posedge clk)
	begin
		hi_r <= (sys_rst || res_valid || !measure_done) ? 32'h0 : hi_r + 32'h1;
		ph_r <= (sys_rst || !test_in_state[4]) ? 32'h0 : ph_r + 32'h1;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence res_verdict;
		res_valid && !test_mode && !dm_r ##1 !test_mode;
	endsequence
	sequence res_digit(h);
		res_valid && !test_mode && dm_r && test_in_state[13] == h ##1 !test_mode;
	endsequence
	verdict_map_a: assert property (res_verdict |-> outs[39:23] == 17'h0
		&& class_lines == $past(res_class)) else $error("verdict outputs wrong");
	digit_high_a: assert property (res_digit(1'b1) |-> digit_lines == $past(res_digits[11:0])
		&& range_code_lines == $past(res_range) && outside_limits == $past(res_upper | res_lower))
		else $error("high digit outputs wrong");
	digit_low_a: assert property (res_digit(1'b0) |-> class_lines == 10'h0
		&& {range_code_lines, digit_lines} == $past(res_digits[27:12]))
		else $error("low digit outputs wrong");
	done_rise_a: assert property (res_valid && !test_mode && (measure_start_external_eff || ac_r)
		##1 !test_mode |-> measure_done) else $error("done did not rise");
	done_none_a: assert property (res_valid && !measure_start_external_eff && !ac_r && !test_mode
		##1 !test_mode |-> !measure_done) else $error("done under manual cal");
	int_width_a: assert property (measure_done && !measure_start_external_eff && !test_mode
		|-> hi_r < 5 * CYC_PER_MS) else $error("internal done too long");
	pulse_width_a: assert property (measure_done && measure_start_external_eff && pul_r && !test_mode
		|-> hi_r < pms_r * CYC_PER_MS) else $error("pulse done too long");
	done_hold_a: assert property (measure_done && measure_start_external_eff && !pul_r && !test_mode
		&& !meas_req && !zero_req && !res_valid && !cfg_wr |=> measure_done)
		else $error("latched done dropped");
	ext_only_a: assert property (meas_req |-> measure_start_external_eff)
		else $error("start event in internal mode");
	send_gate_a: assert property (host_send_req |-> !measure_start_external_eff && de_r)
		else $error("send request not allowed");
	scan_force_a: assert property (test_in_state[5] && $past(test_in_state[5]) && sc_r != 2'h0
		&& !cfg_wr |-> measure_start_external_eff) else $error("scan did not force external");
	print_filter_a: assert property (print_req && fe_r |-> ph_r + 3 >= fms_r * CYC_PER_MS)
		else $error("print passed filter early");
	on_sync_a: assert property ($rose(sweep_halt_pin) |-> ##[1:4] sweep_halt)
		else $error("input on too slow");
	off_sync_a: assert property ($fell(sweep_halt_pin) |-> ##[1:4] !sweep_halt)
		else $error("input off too slow");
	test_drive_a: assert property (test_mode ##1 test_mode |-> outs == $past(test_out))
		else $error("test outputs wrong");
endmodule

bind icp_port icp_port_props #(.CYC_PER_MS(CYC_PER_MS)) u_props (.*);

/* File: icp_plc_model.sv */
// Behavioural outside controller driving the isolated input pins.
`timescale 1ns/1ps
module icp_plc_model (
	input wire logic clk,
	output logic [13:0] pins
);
	// Open inputs read as off, so idle pins sit at zero.
	initial pins = 14'h0;
	task automatic set(input int idx, input logic v);
		pins[idx] = v;
	endtask
	task automatic setv(input logic [13:0] v);
		pins = v;
	endtask
	// Holding past the filter time is the caller's choice of n.
	task automatic press(input int idx, input int n);
		pins[idx] = 1'b1;
		repeat (n) @(posedge clk);
		#1;
		pins[idx] = 1'b0;
	endtask
endmodule

/* File: test_isolated_control_port_logic.sv */
// Self-checking bench for the isolated control port.
`timescale 1ns/1ps
module test_isolated_control_port_logic;
	localparam int unsigned CPM = 10;
	logic clk, sys_rst, cfg_wr, cfg_digit_mode, cfg_measure_start_external, cfg_filter_en;
	logic cfg_measure_start_off_edge, cfg_done_pulse, cfg_auto_cal, cfg_data_out_en, test_mode, res_valid;
	logic [1:0] cfg_scan_mode;
	logic [8:0] cfg_filter_ms, cfg_pulse_ms;
	logic [39:0] test_out;
	logic res_fault = 1'b1, res_ready = 1'b1, res_upper = 1'b0, res_pass = 1'b1, res_lower = 1'b1;
	logic res_overflow = 1'b1;
	logic [2:0] res_temp = 3'h5, res_code = 3'h6;
	logic [9:0] res_class = 10'h2A5;
	logic [27:0] res_digits = 28'h765_4321;
	logic [3:0] res_range = 4'h9;
	wire [13:0] pins;
	logic [13:0] test_in_state;
	logic measure_start_external_eff, meas_req, meas_all_channels, zero_req, print_req, host_send_req;
	logic self_cal_req, panel_lock, sweep_halt, measure_done, fault, ready_next, upper_verdict;
	logic pass_verdict, lower_verdict, overflow_class, outside_limits;
	logic [2:0] temp_verdict, verdict_code_lines;
	logic [9:0] class_lines;
	logic [11:0] digit_lines;
	logic [3:0] range_code_lines;
	logic [5:0] preset_select;
	int n_fail, samples_checked, n_meas, n_zero, n_print, n_host, done_cyc;
	wire measure_start_pin = pins[0];
	wire self_cal_pin = pins[1];
	wire panel_lock_pin = pins[2];
	wire zero_offset_request_pin = pins[3];
	wire print_pin = pins[4];
	wire scanner_terminal_select_pin = pins[5];
	wire sweep_halt_pin = pins[6];
	wire [5:0] preset_select_lines_pin = pins[12:7];
	wire digit_half_select_pin = pins[13];
	wire [39:0] outs = {range_code_lines, digit_lines, outside_limits, verdict_code_lines,
		overflow_class, class_lines, temp_verdict, lower_verdict, pass_verdict, upper_verdict,
		ready_next, fault, measure_done};
	wire [22:0] dig_low = {18'h0, res_pass, 2'h0, res_fault, 1'b1};
	wire [39:0] exp_v = {17'h0, res_code, res_overflow, res_class, res_temp, res_lower, res_pass,
		res_upper, res_ready, res_fault, 1'b1};
	wire [39:0] exp_d1 = {res_range, res_digits[11:0], res_upper | res_lower, dig_low};
	wire [39:0] exp_d0 = {res_digits[27:12], res_upper | res_lower, dig_low};

	icp_port #(.CYC_PER_MS(CPM)) dut (.*);
	icp_plc_model plc (.clk(clk), .pins(pins));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		n_meas += (meas_req === 1'b1);
		n_zero += (zero_req === 1'b1);
		n_print += (print_req === 1'b1);
		n_host += (host_send_req === 1'b1);
		done_cyc += (measure_done === 1'b1);
	end
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic cfg(input logic dm, outside_trigger_source, fe, off, pul, ac, de, input logic [1:0] sc,
		input logic [8:0] pms);
		{cfg_digit_mode, cfg_measure_start_external, cfg_filter_en, cfg_measure_start_off_edge} = {dm, outside_trigger_source, fe, off};
		{cfg_done_pulse, cfg_auto_cal, cfg_data_out_en, cfg_scan_mode} = {pul, ac, de, sc};
		cfg_pulse_ms = pms;
		cfg_wr = 1'b1;
		tick(1);
		cfg_wr = 1'b0;
		tick(1);
	endtask
	task automatic pulse_res;
		res_valid = 1'b1;
		tick(1);
		res_valid = 1'b0;
	endtask
	task automatic t_verdict;
		chk(40'(measure_start_external_eff), 40'h0);
		chk(outs, 40'h0);
		pulse_res;
		chk(outs, exp_v);
		plc.set(13, 1'b1);
		tick(10);
		pulse_res;
		done_cyc = 0;
		chk(outs, exp_v);
		tick(80);
		chk(40'(done_cyc), 40'(5 * CPM));
		cfg(0, 0, 0, 0, 0, 0, 0, 2'h0, 9'h005);
		pulse_res;
		done_cyc = 0;
		tick(20);
		chk(40'(done_cyc), 40'h0);
	endtask
	task automatic t_digit;
		cfg(1, 0, 0, 0, 0, 1, 0, 2'h0, 9'h005);
		pulse_res;
		chk(outs, exp_d1);
		plc.set(13, 1'b0);
		tick(10);
		pulse_res;
		chk(outs, exp_d0);
		tick(60);
	endtask
	task automatic t_external;
		int m0, z0;
		cfg(0, 1, 0, 0, 0, 1, 0, 2'h0, 9'h005);
		pulse_res;
		tick(200);
		chk(40'(measure_done), 40'h1);
		m0 = n_meas;
		plc.press(0, 20);
		chk(40'(n_meas - m0), 40'h1);
		chk(40'(measure_done), 40'h0);
		pulse_res;
		z0 = n_zero;
		plc.press(3, 20);
		chk(40'(n_zero - z0), 40'h1);
		chk(40'(measure_done), 40'h0);
		cfg(0, 1, 0, 1, 0, 1, 0, 2'h0, 9'h005);
		m0 = n_meas;
		plc.set(0, 1'b1);
		tick(20);
		chk(40'(n_meas - m0), 40'h0);
		plc.set(0, 1'b0);
		tick(10);
		chk(40'(n_meas - m0), 40'h1);
		cfg(0, 1, 0, 0, 1, 1, 0, 2'h0, 9'h003);
		pulse_res;
		done_cyc = 0;
		tick(60);
		chk(40'(done_cyc), 40'(3 * CPM));
	endtask
	task automatic t_filter_send;
		int p0, h0, m0;
		cfg(0, 1, 1, 0, 0, 1, 0, 2'h0, 9'h005);
		p0 = n_print;
		plc.press(4, 300);
		tick(10);
		chk(40'(n_print - p0), 40'h0);
		plc.press(4, 600);
		tick(10);
		chk(40'(n_print - p0), 40'h1);
		cfg(0, 0, 0, 0, 0, 1, 1, 2'h0, 9'h005);
		{h0, m0} = {n_host, n_meas};
		plc.press(0, 20);
		tick(10);
		chk(40'(n_host - h0), 40'h1);
		chk(40'(n_meas - m0), 40'h0);
		cfg(0, 0, 0, 0, 0, 1, 0, 2'h1, 9'h005);
		plc.set(5, 1'b1);
		tick(10);
		chk(40'(measure_start_external_eff), 40'h1);
		chk(40'(meas_all_channels), 40'h1);
		cfg(0, 0, 0, 0, 0, 1, 0, 2'h2, 9'h005);
		chk(40'(measure_start_external_eff), 40'h1);
		chk(40'(meas_all_channels), 40'h0);
		plc.set(5, 1'b0);
		tick(10);
		chk(40'(measure_start_external_eff), 40'h0);
	endtask
	task automatic t_test;
		logic [13:0] pat;
		pat = 14'h2A5C;
		plc.setv(pat);
		tick(10);
		chk(40'(test_in_state), 40'(pat));
		chk(40'({sweep_halt, panel_lock, self_cal_req, preset_select}), 40'({pat[6], pat[2], pat[1], pat[12:7]}));
		test_mode = 1'b1;
		test_out = 40'hA5_3C0F_61E8;
		tick(2);
		chk(outs, test_out);
		test_mode = 1'b0;
		plc.setv(14'h0);
		tick(10);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		{sys_rst, cfg_wr, test_mode, res_valid, cfg_digit_mode, cfg_measure_start_external} = 6'h20;
		{cfg_filter_en, cfg_measure_start_off_edge, cfg_done_pulse, cfg_data_out_en} = 4'h0;
		{cfg_auto_cal, cfg_scan_mode, cfg_filter_ms, cfg_pulse_ms} = {1'b1, 2'h0, 9'h032, 9'h005};
		test_out = 40'h0;
		repeat (16) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		tick(1);
		t_verdict;
		t_digit;
		t_external;
		t_filter_send;
		t_test;
		wrap_up;
	end
	// The bound sits well above the longest sequence, so only a hang reaches it.
	initial
	begin
		repeat (100000) @(posedge clk);
		n_fail++;
		wrap_up;
	end
endmodule
